//--- hdl/txpc_pkg.sv
package txpc_pkg;
    // Three-level select encodings (two-bit digital stand-in for ternary pin)
    localparam logic [1:0] TL_LOW   = 2'h0;
    localparam logic [1:0] TL_MID   = 2'h1;
    localparam logic [1:0] TL_HIGH  = 2'h2;
    localparam logic [1:0] TL_FLOAT = 2'h3;

    localparam int CHANNELS   = 4;
    localparam int DATA_W     = 8;
    localparam int CTL_W      = 2;
    localparam int MULT_FULL  = 20;
    localparam int MULT_HALF  = 10;
    localparam int RESET_EDGES = 2;

    typedef enum logic [1:0] {
        TXPC_SRC_REF,
        TXPC_SRC_OWN,
        TXPC_SRC_CHA
    } txpc_src_type;

    // One channel's parallel input character
    typedef struct packed {
        logic [DATA_W-1:0] data;
        logic [CTL_W-1:0]  ctl;
        logic              par;
    } txpc_char_type;
endpackage

//--- hdl/txpc_check.sv
`timescale 1ns/1ps
`default_nettype none
// How it works
// - Phase adjusts while phase-align reset low, frozen while high once the low pulse spanned at least two reference edges.
// - Parity control low: no parity check on any channel.
// - Mid, encoder on: odd parity over data plus parity bit.
// - Mid, encoder bypassed: odd parity over data, control and parity.
// - High: odd parity over data, control and parity always.
// - Floating three-level select reads as mid.
// - Source select: low reference, mid own clock, high channel A clock.
// - Half-rate select gives multiplier twenty when high, ten when low.
module txpc_check
    import txpc_pkg::*;
#(
    parameter int NCH = CHANNELS
) (
    input  wire logic                       CORE_CLK,
    input  wire logic                       RST,
    input  wire logic                       REFERENCE_CLOCK,
    input  wire logic [NCH-1:0]             CHANNEL_INPUT_CLOCK,
    input  wire logic                       PHASE_ALIGN_RESET_N,
    input  wire logic [1:0]                 INPUT_CLOCK_SOURCE_SELECT,
    input  wire logic                       HALF_RATE_REF_SELECT,
    input  wire logic [1:0]                 PARITY_CHECK_CONTROL,
    input  wire logic                       ENCODER_ENABLE,
    input  wire txpc_char_type [NCH-1:0]    CHANNEL_CHAR_IN,
    output logic [NCH-1:0]                  PARITY_ERROR,
    output logic [NCH-1:0]                  CHAR_STROBE,
    output logic [NCH-1:0]                  PHASE_LOCKED,
    output logic                            MODE_INVALID,
    output logic [4:0]                      PLL_MULTIPLIER
);

    // Ternary pin decode; float self-biases to mid
    function automatic logic [1:0] tl_decode(input logic [1:0] v);
        tl_decode = (v == TL_FLOAT) ? TL_MID : v;
    endfunction

    // Odd parity over selected bits; returns 1 on failure
    function automatic logic par_fail(input txpc_char_type c,
                                      input logic with_ctl);
        logic x;
        x = ^c.data ^ c.par;
        if (with_ctl) begin
            x = x ^ (^c.ctl);
        end
        par_fail = ~x;
    endfunction

    // Async pins: two-stage synchronisers
    logic [NCH+1:0] meta;
    logic [NCH+1:0] sync;
    logic [NCH+1:0] sync_d;
    logic [NCH+1:0] next_sync_d;
    txpc_char_type [NCH-1:0] char_meta;
    txpc_char_type [NCH-1:0] char_sync;
    logic [5:0]     cfg_meta;
    logic [5:0]     cfg_sync;

    always_ff @(posedge CORE_CLK) begin
        if (RST) begin
            meta      <= '0;
            sync      <= '0;
            char_meta <= '0;
            char_sync <= '0;
            cfg_meta  <= '0;
            cfg_sync  <= '0;
        end else begin
            meta      <= {PHASE_ALIGN_RESET_N, REFERENCE_CLOCK,
                          CHANNEL_INPUT_CLOCK};
            sync      <= meta;
            char_meta <= CHANNEL_CHAR_IN;
            char_sync <= char_meta;
            // Selects are static, so skew between their bits is harmless
            cfg_meta  <= {INPUT_CLOCK_SOURCE_SELECT, HALF_RATE_REF_SELECT,
                          PARITY_CHECK_CONTROL, ENCODER_ENABLE};
            cfg_sync  <= cfg_meta;
        end
    end

    // Delayed copy for edge detection, reads only second stage
    always_comb begin
        next_sync_d = sync;
    end

    always_ff @(posedge CORE_CLK) begin
        if (RST) begin
            sync_d <= '0;
        end else begin
            sync_d <= next_sync_d;
        end
    end

    logic [NCH-1:0] ch_rise;
    logic           ref_rise;
    logic           par_n_s;
    assign ch_rise  = sync[NCH-1:0] & ~sync_d[NCH-1:0];
    assign ref_rise = sync[NCH] & ~sync_d[NCH];
    assign par_n_s  = sync[NCH+1];

    // Synchronised selects, split back into their fields
    logic [1:0]   sel_s;
    logic         half_s;
    logic [1:0]   pctl_s;
    logic         enc_s;
    assign {sel_s, half_s, pctl_s, enc_s} = cfg_sync;

    // Configuration decode, from the synchronised copy only
    txpc_src_type src;
    logic [1:0]   pctl;
    always_comb begin
        unique case (tl_decode(sel_s))
            TL_LOW:  src = TXPC_SRC_REF;
            TL_MID:  src = TXPC_SRC_OWN;
            default: src = TXPC_SRC_CHA;
        endcase
        pctl = tl_decode(pctl_s);
    end

    // Flag for the host-side illegal combination; device keeps running
    logic         mode_bad;
    logic         next_mode_bad;
    logic [4:0]   mult;
    logic [4:0]   next_mult;
    always_comb begin
        next_mode_bad = half_s && (src != TXPC_SRC_REF);
        next_mult     = half_s ? 5'(MULT_FULL) : 5'(MULT_HALF);
    end

    // Registered: status words lag the pins by three cycles
    always_ff @(posedge CORE_CLK) begin
        if (RST) begin
            mode_bad <= 1'b0;
            mult     <= 5'(MULT_HALF);
        end else begin
            mode_bad <= next_mode_bad;
            mult     <= next_mult;
        end
    end
    assign MODE_INVALID   = mode_bad;
    assign PLL_MULTIPLIER = mult;

    // Phase alignment: low reset sampled on reference edges adjusts phase
    logic [1:0]     low_cnt;
    logic [1:0]     next_low_cnt;
    logic [NCH-1:0] locked;
    logic [NCH-1:0] next_locked;
    always_comb begin
        next_low_cnt = low_cnt;
        next_locked  = locked;
        if (ref_rise) begin
            if (!par_n_s) begin
                if (low_cnt < 2'(RESET_EDGES)) begin
                    next_low_cnt = low_cnt + 2'h1;
                end
                next_locked = '0;
            end else begin
                next_low_cnt = 2'h0;
                // Freeze only after a full-length reset pulse
                if (low_cnt >= 2'(RESET_EDGES)) begin
                    next_locked = '1;
                end
            end
        end
    end

    always_ff @(posedge CORE_CLK) begin
        if (RST) begin
            low_cnt <= 2'h0;
            locked  <= '0;
        end else begin
            low_cnt <= next_low_cnt;
            locked  <= next_locked;
        end
    end
    assign PHASE_LOCKED = locked;

    // Per-channel input register strobe from selected clock
    logic [NCH-1:0] strobe;
    always_comb begin
        for (int i = 0; i < NCH; i++) begin
            unique case (src)
                TXPC_SRC_REF: strobe[i] = ref_rise;
                TXPC_SRC_OWN: strobe[i] = ch_rise[i];
                TXPC_SRC_CHA: strobe[i] = ch_rise[0];
            endcase
        end
    end

    // Parity check registered on the capturing strobe
    logic [NCH-1:0] perr;
    logic [NCH-1:0] next_perr;
    logic [NCH-1:0] stb;
    logic [NCH-1:0] next_stb;
    always_comb begin
        next_perr = perr;
        next_stb  = strobe;
        for (int i = 0; i < NCH; i++) begin
            if (strobe[i]) begin
                unique case (pctl)
                    TL_LOW:  next_perr[i] = 1'b0;
                    TL_MID:  next_perr[i] = par_fail(char_sync[i],
                                 !enc_s);
                    default: next_perr[i] = par_fail(char_sync[i],
                                 1'b1);
                endcase
            end
        end
    end

    always_ff @(posedge CORE_CLK) begin
        if (RST) begin
            perr <= '0;
            stb  <= '0;
        end else begin
            perr <= next_perr;
            stb  <= next_stb;
        end
    end
    assign PARITY_ERROR = perr;
    assign CHAR_STROBE  = stb;

endmodule
`default_nettype wire

//--- tb/txpc_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module txpc_monitor
    import txpc_pkg::*;
(
    input  wire logic       CORE_CLK,
    input  wire logic       RST,
    input  wire logic       REFERENCE_CLOCK,
    input  wire logic [3:0] CHANNEL_INPUT_CLOCK,
    input  wire logic       PHASE_ALIGN_RESET_N,
    input  wire logic [1:0] INPUT_CLOCK_SOURCE_SELECT,
    input  wire logic       HALF_RATE_REF_SELECT,
    input  wire logic [1:0] PARITY_CHECK_CONTROL,
    input  wire logic [3:0] PARITY_ERROR,
    input  wire logic [3:0] CHAR_STROBE,
    input  wire logic [3:0] PHASE_LOCKED,
    input  wire logic       MODE_INVALID,
    input  wire logic [4:0] PLL_MULTIPLIER
);
    default clocking @(posedge CORE_CLK); endclocking
    default disable iff (RST);
    // Configuration decode and clock-to-strobe timing
    // Selects pass two sync stages and a register before these outputs
    pll_mult_a: assert property (
        !$past(RST, 1) && !$past(RST, 2) && !$past(RST, 3)
        |-> PLL_MULTIPLIER
            == ($past(HALF_RATE_REF_SELECT, 3) ? 5'h14 : 5'h0A))
        else $error("multiplier wrong");
    bad_mode_a: assert property (
        !$past(RST, 1) && !$past(RST, 2) && !$past(RST, 3)
        |-> MODE_INVALID == ($past(HALF_RATE_REF_SELECT, 3)
            && $past(INPUT_CLOCK_SOURCE_SELECT, 3) != TL_LOW))
        else $error("mode flag");
    par_off_a: assert property (
        CHAR_STROBE[0] && PARITY_CHECK_CONTROL == TL_LOW |-> !PARITY_ERROR[0])
        else $error("error while off");
    strobe_once_a: assert property (
        CHAR_STROBE[0] |=> !CHAR_STROBE[0]) else $error("strobe too long");
    err_hold_a: assert property (
        !CHAR_STROBE[0] |-> $stable(PARITY_ERROR[0])) else $error("error moved");
    ref_strobe_a: assert property (
        INPUT_CLOCK_SOURCE_SELECT == TL_LOW && $rose(REFERENCE_CLOCK)
        |-> ##[3:4] CHAR_STROBE[0]) else $error("ref strobe late");
    own_strobe_a: assert property (
        INPUT_CLOCK_SOURCE_SELECT[0] && $rose(CHANNEL_INPUT_CLOCK[1])
        |-> ##[3:4] CHAR_STROBE[1]) else $error("own strobe late");
    cha_strobe_a: assert property (
        INPUT_CLOCK_SOURCE_SELECT == TL_HIGH && $rose(CHANNEL_INPUT_CLOCK[0])
        |-> ##[3:4] CHAR_STROBE[3]) else $error("chan A strobe late");
    phase_free_a: assert property (
        !PHASE_ALIGN_RESET_N && $rose(REFERENCE_CLOCK)
        |-> ##[1:6] !PHASE_LOCKED[0]) else $error("phase not freed");
endmodule
`default_nettype wire

//--- tb/txpc_host.sv
`timescale 1ns/1ps
`default_nettype none
module txpc_host
    import txpc_pkg::*;
(
    input  wire logic                go,
    input  wire txpc_char_type [3:0] chr,
    output logic                     ref_clk,
    output logic [3:0]               ch_clk,
    output txpc_char_type [3:0]      pin
);
    // Clocks idle low between frames; released data is inverted garbage
    initial begin
        ref_clk = 0;
        ch_clk = 0;
        pin = '1;
    end
    // One character per frame, channel clocks staggered in phase
    always @(posedge go) begin
        pin = chr;
        #20 ref_clk = 1;
        for (int i = 0; i < 4; i++)
            #10 ch_clk[i] = 1;
        ref_clk = 0;
        // Each clock stays high for 40 ns, once per frame
        for (int i = 0; i < 4; i++)
            #10 ch_clk[i] = 0;
        #40 pin = ~chr;
    end
endmodule
`default_nettype wire

//--- tb/tx_input_clock_parity_check_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tx_input_clock_parity_check_tb_top
    import txpc_pkg::*;
;
    logic                CORE_CLK, RST, go, pa_n, half, enc, inv;
    logic [1:0]          sel, pcc;
    logic                ref_clk;
    logic [3:0]          ch_clk, perr, stb, lock;
    logic [4:0]          mult;
    txpc_char_type [3:0] chr, pin;
    int                  miscompares, checks, cyc, nstb, nbase;
    txpc_check dut (.CORE_CLK(CORE_CLK), .RST(RST), .REFERENCE_CLOCK(ref_clk),
        .CHANNEL_INPUT_CLOCK(ch_clk), .PHASE_ALIGN_RESET_N(pa_n),
        .INPUT_CLOCK_SOURCE_SELECT(sel), .HALF_RATE_REF_SELECT(half),
        .PARITY_CHECK_CONTROL(pcc), .ENCODER_ENABLE(enc),
        .CHANNEL_CHAR_IN(pin), .PARITY_ERROR(perr), .CHAR_STROBE(stb),
        .PHASE_LOCKED(lock), .MODE_INVALID(inv), .PLL_MULTIPLIER(mult));
    txpc_host host (.go(go), .chr(chr), .ref_clk(ref_clk), .ch_clk(ch_clk),
        .pin(pin));
    task automatic chk(string n, logic [4:0] e, logic [4:0] s);
        checks++;
        if (s !== e) begin
            miscompares++;
            $display("ERROR %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic close_out();
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    // Odd parity; control bits join unless encoder on at mid level
    function automatic logic [3:0] exp_err(txpc_char_type [3:0] c);
        logic [3:0] r;
        for (int i = 0; i < 4; i++)
            r[i] = pcc != TL_LOW && !(^{c[i].data, c[i].par}
                ^ ((pcc == TL_HIGH || !enc) && ^c[i].ctl));
        return r;
    endfunction
    // One random character on every channel, then count and judge
    task automatic frame();
        chr = 44'({$urandom, $urandom});
        nbase = nstb;
        go = 1;
        @(negedge CORE_CLK) go = 0;
        repeat (20) @(negedge CORE_CLK);
        chk("strobes", 5'h4, 5'(nstb - nbase));
        chk("perr", {1'b0, exp_err(chr)}, {1'b0, perr});
    endtask
    initial begin
        CORE_CLK = 0;
        forever #5 CORE_CLK = ~CORE_CLK;
    end
    // Strobe tally and hang guard, about eight times the expected run
    always @(posedge CORE_CLK) begin
        nstb += $countones(stb);
        cyc++;
        if (cyc == 20000) begin
            miscompares++;
            close_out();
        end
    end
    initial begin
        {RST, go, pa_n, half, enc, sel, pcc, chr} = {3'h4, 2'h1, 4'h1, 44'h0};
        void'($urandom(91));
        repeat (12) @(negedge CORE_CLK);
        RST = 0;
        // Lock, then a second phase-align pulse mid-run, then relock
        for (int k = 0; k < 2; k++) begin
            pa_n = 0;
            repeat (2) frame();
            chk("unlocked", 5'h0, {1'b0, lock});
            pa_n = 1;
            repeat (2) frame();
            chk("locked", 5'h0F, {1'b0, lock});
        end
        // Every source, parity level and encoder setting in turn
        for (int m = 0; m < 32; m++) begin
            {sel, pcc, enc} = 5'(m);
            half = 1'($urandom);
            repeat (4) @(negedge CORE_CLK);
            chk("mult", half ? 5'h14 : 5'h0A, mult);
            chk("invalid", {4'h0, half && sel != TL_LOW}, {4'h0, inv});
            // Half rate only with reference clocking once frames run
            if (sel != TL_LOW)
                half = 1'b0;
            repeat (4) @(negedge CORE_CLK);
            repeat (3) frame();
        end
        close_out();
    end
endmodule
bind txpc_check txpc_monitor mon (.*);
`default_nettype wire
